// *** aipc_defines.vh ***
// Register map, field positions, reset values and codes for the activity/inactivity power control block
`ifndef AIPC_DEFINES_VH
`define AIPC_DEFINES_VH

`define AIPC_ADDR_CFG        8'h00
`define AIPC_ADDR_DUR        8'h04
`define AIPC_ADDR_ROUTE      8'h08
`define AIPC_ADDR_STATUS     8'h0C
`define AIPC_ADDR_IRQ_STAT   8'h10
`define AIPC_ADDR_IRQ_MASK   8'h14
`define AIPC_ADDR_ACCEL      8'h18

`define AIPC_CFG_THR_LSB     0
`define AIPC_CFG_THR_MSB     5
`define AIPC_CFG_INACT_LSB   6
`define AIPC_CFG_INACT_MSB   7
`define AIPC_CFG_FSEL_BIT    8
`define AIPC_CFG_GIE_BIT     9
`define AIPC_CFG_RESET       10'h000

`define AIPC_ROUTE_PIN1_BIT  0
`define AIPC_ROUTE_PIN2_BIT  1

`define AIPC_ST_SLEEP_BIT    0
`define AIPC_ST_GYRO_LSB     1
`define AIPC_ST_GYRO_MSB     2
`define AIPC_ST_LOWRATE_BIT  3

`define AIPC_EV_INACT_BIT    0
`define AIPC_EV_ACT_BIT      1

`define AIPC_INACT_OFF       2'h0
`define AIPC_INACT_GYRO_KEEP 2'h1
`define AIPC_INACT_GYRO_SLP  2'h2
`define AIPC_INACT_GYRO_PD   2'h3

`define AIPC_GYRO_NORMAL     2'h0
`define AIPC_GYRO_SLEEP      2'h1
`define AIPC_GYRO_POWERDOWN  2'h2

`define AIPC_RATE_12HZ5      4'h1
`define AIPC_ACCEL_RESET     4'h0
`define AIPC_SAMPLES_PER_DUR 512

`endif

// *** aipc_axis_cmp.v ***
// Per-axis magnitude compare of filtered samples against the wake threshold
`timescale 1ns/10ps
`default_nettype none
`include "aipc_defines.vh"

module aipc_axis_cmp #(
  parameter AXES = 3,
  parameter DW   = 16
) (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 rst_i,
  // Sample inputs
  input  wire                 valid_i,
  input  wire [AXES*DW-1:0]   slope_i,
  input  wire [AXES*DW-1:0]   hpf_i,
  input  wire                 filter_select_i,
  input  wire [5:0]           wake_threshold_i,
  input  wire [1:0]           accel_full_scale_i,
  // Results
  output reg                  valid_o,
  output reg                  above_o
);

  wire [AXES-1:0] axis_above;

  genvar g;
  generate
    for (g = 0; g < AXES; g = g + 1)
    begin : g_axis
      wire [DW-1:0] smp = filter_select_i ? hpf_i[g*DW +: DW] : slope_i[g*DW +: DW];
      wire [DW-1:0] mag = smp[DW-1] ? (~smp + {{(DW-1){1'b0}}, 1'b1}) : smp;
      // One threshold step is full scale / 64, i.e. sample >> (DW-7) at full scale code
      wire [DW-1:0] thr = {{(DW-6){1'b0}}, wake_threshold_i} << (DW - 7);
      assign axis_above[g] = mag > thr;
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid_o <= 1'b0;
      above_o <= 1'b0;
    end
    else
    begin
      valid_o <= valid_i;
      above_o <= |axis_above;
    end
  end

  // Full scale only sets the mg weight of a step; samples are already scaled to it
  wire unused_fs = ^accel_full_scale_i;

endmodule // aipc_axis_cmp
`default_nettype wire

// *** aipc_core.v ***
// Activity/inactivity recognizer with rate override, gyro control and Wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "aipc_defines.vh"

module aipc_core #(
  parameter AXES = 3,
  parameter DW   = 16
) (
  // Clock and reset
  input  wire                 clk_i,
  input  wire                 rst_i,
  // Wishbone slave
  input  wire                 cyc_i,
  input  wire                 stb_i,
  input  wire                 we_i,
  input  wire [7:0]           adr_i,
  input  wire [3:0]           sel_i,
  input  wire [31:0]          dat_i,
  output reg  [31:0]          dat_o,
  output reg                  ack_o,
  // Filter chain samples
  input  wire                 sample_valid_i,
  input  wire [AXES*DW-1:0]   slope_data_i,
  input  wire [AXES*DW-1:0]   hpf_data_i,
  // Sampling control
  output reg  [3:0]           accel_rate_o,
  output reg                  accel_low_power_o,
  output reg  [1:0]           gyro_mode_o,
  // Interrupts
  output reg                  irq_pin_a_o,
  output reg                  irq_pin_b_o,
  output reg                  irq_o
);

  localparam ST_ACTIVE   = 2'b01;
  localparam ST_INACTIVE = 2'b10;

  reg  [9:0]  cfg_q;
  reg  [3:0]  sleep_duration_q;
  reg  [1:0]  accel_full_scale_q;
  reg  [1:0]  route_q;
  reg  [3:0]  accel_rate_q;
  reg  [1:0]  gyro_user_q;
  reg  [1:0]  ev_stat_q;
  reg  [1:0]  ev_mask_q;
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [12:0] quiet_cnt_q;
  reg  [12:0] quiet_cnt_d;
  reg  [1:0]  ev_pulse_q;
  reg  [1:0]  ev_pulse_d;

  wire [5:0]  wake_threshold    = cfg_q[`AIPC_CFG_THR_MSB:`AIPC_CFG_THR_LSB];
  wire [1:0]  inactivity_config = cfg_q[`AIPC_CFG_INACT_MSB:`AIPC_CFG_INACT_LSB];
  wire        filter_select     = cfg_q[`AIPC_CFG_FSEL_BIT];
  wire        global_irq_en     = cfg_q[`AIPC_CFG_GIE_BIT];
  wire        func_en = global_irq_en && (inactivity_config != `AIPC_INACT_OFF);
  wire        sleeping = state_q[1];

  wire        cmp_valid;
  wire        cmp_above;

  aipc_axis_cmp #(
    .AXES (AXES),
    .DW   (DW)
  ) u_cmp (
    .clk_i              (clk_i),
    .rst_i              (rst_i),
    .valid_i            (sample_valid_i),
    .slope_i            (slope_data_i),
    .hpf_i              (hpf_data_i),
    .filter_select_i    (filter_select),
    .wake_threshold_i   (wake_threshold),
    .accel_full_scale_i (accel_full_scale_q),
    .valid_o            (cmp_valid),
    .above_o            (cmp_above)
  );

  // Quiet target: units of 512 samples; zero duration means inactivity at first quiet sample
  wire [12:0] quiet_target = {sleep_duration_q, 9'h000};

  always @*
  begin
    state_d     = state_q;
    quiet_cnt_d = quiet_cnt_q;
    ev_pulse_d  = ev_pulse_q;
    if (!func_en)
    begin
      state_d     = ST_ACTIVE;
      quiet_cnt_d = quiet_cnt_q;
    end
    else if (cmp_valid)
    begin
      // Event pulse spans exactly one sample period
      ev_pulse_d = 2'b00;
      case (state_q)
        ST_ACTIVE:
        begin
          if (cmp_above)
            quiet_cnt_d = 13'h0000;
          else if (quiet_cnt_q + 13'h0001 >= quiet_target)
          begin
            state_d     = ST_INACTIVE;
            quiet_cnt_d = 13'h0000;
            ev_pulse_d  = 2'b01;
          end
          else
            quiet_cnt_d = quiet_cnt_q + 13'h0001;
        end
        ST_INACTIVE:
        begin
          if (cmp_above)
          begin
            state_d    = ST_ACTIVE;
            ev_pulse_d = 2'b10;
          end
        end
        default:
        begin
          state_d = ST_ACTIVE;
        end
      endcase
    end
  end

  // Register read mux
  reg [31:0] rd_data;
  always @*
  begin
    case (adr_i)
      `AIPC_ADDR_CFG:      rd_data = {22'h00_0000, cfg_q};
      `AIPC_ADDR_DUR:      rd_data = {26'h000_0000, accel_full_scale_q, sleep_duration_q};
      `AIPC_ADDR_ROUTE:    rd_data = {30'h0000_0000, route_q};
      `AIPC_ADDR_STATUS:   rd_data = {28'h000_0000, accel_low_power_o, gyro_mode_o, sleeping};
      `AIPC_ADDR_IRQ_STAT: rd_data = {30'h0000_0000, ev_stat_q};
      `AIPC_ADDR_IRQ_MASK: rd_data = {30'h0000_0000, ev_mask_q};
      `AIPC_ADDR_ACCEL:    rd_data = {26'h000_0000, gyro_user_q, accel_rate_q};
      default:             rd_data = 32'h0000_0000;
    endcase
  end

  wire bus_req  = cyc_i && stb_i && !ack_o;
  wire wr_b0    = bus_req && we_i && sel_i[0];
  wire wr_b1    = bus_req && we_i && sel_i[1];
  wire stat_rd  = bus_req && !we_i && (adr_i == `AIPC_ADDR_IRQ_STAT);

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q              <= `AIPC_CFG_RESET;
      sleep_duration_q   <= 4'h0;
      accel_full_scale_q <= 2'h0;
      route_q            <= 2'h0;
      accel_rate_q       <= `AIPC_ACCEL_RESET;
      gyro_user_q        <= `AIPC_GYRO_NORMAL;
      ev_stat_q          <= 2'h0;
      ev_mask_q          <= 2'h0;
      state_q            <= ST_ACTIVE;
      quiet_cnt_q        <= 13'h0000;
      ev_pulse_q         <= 2'h0;
      ack_o              <= 1'b0;
      dat_o              <= 32'h0000_0000;
      accel_rate_o       <= `AIPC_ACCEL_RESET;
      accel_low_power_o  <= 1'b0;
      gyro_mode_o        <= `AIPC_GYRO_NORMAL;
      irq_pin_a_o        <= 1'b0;
      irq_pin_b_o        <= 1'b0;
      irq_o              <= 1'b0;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
        dat_o <= rd_data;
      if (wr_b0)
      begin
        case (adr_i)
          `AIPC_ADDR_CFG:      cfg_q[7:0] <= dat_i[7:0];
          `AIPC_ADDR_DUR:      {accel_full_scale_q, sleep_duration_q} <= dat_i[5:0];
          `AIPC_ADDR_ROUTE:    route_q <= dat_i[1:0];
          `AIPC_ADDR_IRQ_MASK: ev_mask_q <= dat_i[1:0];
          `AIPC_ADDR_ACCEL:    {gyro_user_q, accel_rate_q} <= dat_i[5:0];
          default:             ;
        endcase
      end
      if (wr_b1 && adr_i == `AIPC_ADDR_CFG)
        cfg_q[9:8] <= dat_i[9:8];

      state_q     <= state_d;
      quiet_cnt_q <= quiet_cnt_d;
      ev_pulse_q  <= ev_pulse_d;

      // New event wins over the read-to-clear in the same cycle
      ev_stat_q <= (stat_rd ? 2'b00 : ev_stat_q) | (ev_pulse_d & ~ev_pulse_q);

      // Programmed rate stays untouched; only the applied rate is overridden
      if (state_d == ST_INACTIVE)
      begin
        accel_rate_o      <= `AIPC_RATE_12HZ5;
        accel_low_power_o <= 1'b1;
        case (inactivity_config)
          `AIPC_INACT_GYRO_SLP: gyro_mode_o <= `AIPC_GYRO_SLEEP;
          `AIPC_INACT_GYRO_PD:  gyro_mode_o <= `AIPC_GYRO_POWERDOWN;
          default:              gyro_mode_o <= gyro_user_q;
        endcase
      end
      else
      begin
        accel_rate_o      <= accel_rate_q;
        accel_low_power_o <= 1'b0;
        gyro_mode_o       <= gyro_user_q;
      end

      irq_pin_a_o <= route_q[`AIPC_ROUTE_PIN1_BIT] && state_d[1];
      irq_pin_b_o <= route_q[`AIPC_ROUTE_PIN2_BIT] && state_d[1];
      irq_o       <= |(((stat_rd ? 2'b00 : ev_stat_q) | (ev_pulse_d & ~ev_pulse_q)) & ev_mask_q);
    end
  end

  wire unused_bus = ^{dat_i[31:10], sel_i[3:2]};

endmodule // aipc_core
`default_nettype wire

// *** aipc_core_chk.sv ***
// Port checker for the activity/inactivity core
`timescale 1ns/10ps
`default_nettype none
`include "aipc_defines.vh"
module aipc_core_chk #(
  parameter AXES = 3,
  parameter DW   = 16
) (
  // Clock, reset and bus
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [7:0]           adr_i,
  input wire logic [31:0]          dat_o,
  input wire logic                 ack_o,
  // Samples and outputs
  input wire logic                 sample_valid_i,
  input wire logic [AXES*DW-1:0]   slope_data_i,
  input wire logic [AXES*DW-1:0]   hpf_data_i,
  input wire logic [3:0]           accel_rate_o,
  input wire logic                 accel_low_power_o,
  input wire logic                 irq_pin_a_o,
  input wire logic                 irq_pin_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Full scale on axis 0 beats any 6-bit threshold
  sequence s_loud;
    sample_valid_i && slope_data_i[15:0] == 16'h7FFF && hpf_data_i[15:0] == 16'h7FFF && accel_low_power_o;
  endsequence
  a_ack_next: assert property (s_take |=> ack_o) else $error("ack missing");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_lp_rate: assert property (
    accel_low_power_o |-> accel_rate_o == `AIPC_RATE_12HZ5) else $error("rate not overridden");
  a_pin_a_state: assert property (irq_pin_a_o |-> accel_low_power_o) else $error("pin a high awake");
  a_pin_b_state: assert property (irq_pin_b_o |-> accel_low_power_o) else $error("pin b high awake");
  a_enter_cause: assert property (
    $rose(accel_low_power_o) |-> $past(sample_valid_i, 2)) else $error("sleep without sample");
  a_wake_now: assert property (s_loud |-> ##2 !accel_low_power_o) else $error("wake late");
  a_flag_read: assert property (
    ack_o && !$past(we_i) && $past(adr_i) == `AIPC_ADDR_STATUS
    |-> dat_o[`AIPC_ST_SLEEP_BIT] == $past(accel_low_power_o)) else $error("sleep flag wrong");
endmodule // aipc_core_chk
bind aipc_core aipc_core_chk #(.AXES(AXES), .DW(DW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i), .slope_data_i(slope_data_i),
  .hpf_data_i(hpf_data_i), .accel_rate_o(accel_rate_o), .accel_low_power_o(accel_low_power_o),
  .irq_pin_a_o(irq_pin_a_o), .irq_pin_b_o(irq_pin_b_o));
`default_nettype wire

// *** aipc_host_model.sv ***
// Host model: counts interrupt and pin requests
`timescale 1ns/10ps
`default_nettype none
module aipc_host_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Request lines
  input  wire logic irq_i,
  input  wire logic pin_a_i,
  // Rising request counts
  output var  int   n_irq_o,
  output var  int   n_pin_o
);
  logic irq_q;
  logic pin_q;
  // Host reacts to edges; a held level is one request
  always @(posedge clk_i)
  begin
    irq_q <= rst_i ? 1'b0 : irq_i;
    pin_q <= rst_i ? 1'b0 : pin_a_i;
    n_irq_o <= rst_i ? 0 : n_irq_o + int'(irq_i && !irq_q);
    n_pin_o <= rst_i ? 0 : n_pin_o + int'(pin_a_i && !pin_q);
  end
endmodule // aipc_host_model
`default_nettype wire

// *** aipc_core_tb.sv ***
// Self-checking bench for the activity/inactivity core
`timescale 1ns/10ps
`default_nettype none
`include "aipc_defines.vh"
module aipc_core_tb;
  typedef struct packed {logic [9:0] cfg; logic [15:0] s; logic [15:0] h; logic lp; logic [1:0] gy;} aipc_row_t;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sample_valid_i = 0;
  logic [7:0]  adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, q;
  logic [47:0] slope_data_i = 0, hpf_data_i = 0;
  logic [3:0]  accel_rate_o;
  logic [1:0]  gyro_mode_o;
  logic        accel_low_power_o, irq_pin_a_o, irq_pin_b_o, irq_o, ack_o;
  int          n_fail = 0, n_checks = 0, n_irq, n_pin, i;
  // Threshold 2 gives a limit of magnitude 1024
  aipc_row_t rows [12] = '{
    '{10'h242, 16'h0000, 16'h0000, 1, 0}, '{10'h242, 16'h7FFF, 16'h7FFF, 0, 0},
    '{10'h282, 16'h0000, 16'h0000, 1, 1}, '{10'h282, 16'h07D0, 16'h0000, 0, 0},
    '{10'h2C2, 16'h0000, 16'h0000, 1, 2}, '{10'h3C2, 16'h7FFF, 16'h0000, 1, 2},
    '{10'h3C2, 16'h0000, 16'h07D0, 0, 0}, '{10'h0C2, 16'h0000, 16'h0000, 0, 0},
    '{10'h202, 16'h0000, 16'h0000, 0, 0}, '{10'h242, 16'h0000, 16'h0000, 1, 0},
    '{10'h242, 16'hFC00, 16'hFC00, 1, 0}, '{10'h242, 16'hFBFF, 16'hFBFF, 0, 0}};
  aipc_core DUT (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
    .slope_data_i(slope_data_i), .hpf_data_i(hpf_data_i), .accel_rate_o(accel_rate_o),
    .accel_low_power_o(accel_low_power_o), .gyro_mode_o(gyro_mode_o), .irq_pin_a_o(irq_pin_a_o),
    .irq_pin_b_o(irq_pin_b_o), .irq_o(irq_o));
  aipc_host_model u_host (
    .clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .pin_a_i(irq_pin_a_o), .n_irq_o(n_irq), .n_pin_o(n_pin));
  initial
  begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic summarize;
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; k < 9; k++)
    begin
      @(posedge clk_i);
      #1;
      if (ack_o === 1'b1)
        break;
    end
    if (k == 9)
    begin
      n_fail++;
      summarize();
    end
    q = dat_o;
    @(posedge clk_i);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic smp(input logic [15:0] s, input logic [15:0] h);
    @(posedge clk_i);
    sample_valid_i <= 1;
    slope_data_i <= {3{s}};
    hpf_data_i <= {3{h}};
    @(posedge clk_i);
    sample_valid_i <= 0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    #1;
    chk("reset_out", 0, {accel_rate_o, accel_low_power_o, gyro_mode_o, irq_pin_a_o, irq_pin_b_o, irq_o});
    wb(0, `AIPC_ADDR_CFG, 0);
    chk("cfg_reset", 0, q);
    wb(1, `AIPC_ADDR_ACCEL, 32'h0000_0006);
    wb(1, `AIPC_ADDR_ROUTE, 1);
    wb(1, `AIPC_ADDR_IRQ_MASK, 3);
    wb(1, `AIPC_ADDR_DUR, 0);
    for (i = 0; i < 12; i++)
    begin
      wb(1, `AIPC_ADDR_CFG, {22'h0, rows[i].cfg});
      smp(rows[i].s, rows[i].h);
      chk("low_power", rows[i].lp, accel_low_power_o);
      chk("gyro", rows[i].gy, gyro_mode_o);
      chk("rate", rows[i].lp ? `AIPC_RATE_12HZ5 : 4'h6, accel_rate_o);
      chk("pin_a", rows[i].lp, irq_pin_a_o);
      chk("pin_b", 0, irq_pin_b_o);
    end
    chk("irq", 1, irq_o);
    chk("host_irq", 1, n_irq);
    chk("host_pin", 4, n_pin);
    wb(0, `AIPC_ADDR_IRQ_STAT, 0);
    chk("irq_stat", 3, q);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq_clear", 0, irq_o);
    wb(0, 8'hFC, 0);
    chk("unmapped", 0, q);
    wb(1, `AIPC_ADDR_ROUTE, 2);
    wb(1, `AIPC_ADDR_IRQ_MASK, 0);
    wb(1, `AIPC_ADDR_DUR, 1);
    wb(1, `AIPC_ADDR_CFG, 32'h0000_0242);
    repeat (300) smp(0, 0);
    smp(16'h07D0, 0);
    repeat (511) smp(0, 0);
    chk("early", 0, accel_low_power_o);
    smp(0, 0);
    chk("asleep", 1, accel_low_power_o);
    chk("pin_b_on", 1, irq_pin_b_o);
    chk("pin_a_off", 0, irq_pin_a_o);
    chk("masked", 0, irq_o);
    wb(0, `AIPC_ADDR_STATUS, 0);
    chk("sleep_flag", 1, q[0]);
    wb(0, `AIPC_ADDR_ACCEL, 0);
    chk("accel_reg", 6, q[3:0]);
    wb(0, `AIPC_ADDR_IRQ_STAT, 0);
    chk("stat_masked", 1, q[1:0]);
    summarize();
  end
endmodule // aipc_core_tb
`default_nettype wire
